// ===== pkg/evpsc_defines.svh
/*
 * constants for the pilot state controller: timing counts, band codes,
 * pwm figures. assumes a 125 MHz system clock.
 */
`ifndef EVPSC_DEFINES_SVH
`define EVPSC_DEFINES_SVH

// ---------------------------------------------------------------
// clock and timing
// ---------------------------------------------------------------
`define EVPSC_CLK_HZ 125000000
// background tick rate in hz
`define EVPSC_TICK_HZ 4000
`define EVPSC_TICK_DIV (`EVPSC_CLK_HZ / `EVPSC_TICK_HZ)
// pilot pwm frequency in hz (nominal 1 khz)
`define EVPSC_PWM_HZ 1000
`define EVPSC_PWM_PERIOD (`EVPSC_CLK_HZ / `EVPSC_PWM_HZ)
// high-time duty in percent, advertises 15 a
`define EVPSC_PWM_DUTY_PCT 25
`define EVPSC_PWM_HIGH (`EVPSC_PWM_PERIOD * `EVPSC_PWM_DUTY_PCT / 100)
// self-test response window in ms, counted in 4 khz ticks
`define EVPSC_ST_WAIT_MS 30
`define EVPSC_ST_WAIT_TICKS (`EVPSC_ST_WAIT_MS * `EVPSC_TICK_HZ / 1000)
// burst length in ticks (one tick per coil toggle)
`define EVPSC_ST_BURST_TICKS 16

// ---------------------------------------------------------------
// pilot band codes from the level comparator
// ---------------------------------------------------------------
`define EVPSC_BAND_A 3'h0
`define EVPSC_BAND_B 3'h1
`define EVPSC_BAND_C 3'h2
`define EVPSC_BAND_D 3'h3
`define EVPSC_BAND_INV 3'h4

`endif

// ===== pkg/evpsc_pkg.sv
/*
 * types for the pilot state controller.
 * assumes evpsc_defines.svh for numeric constants.
 */
package evpsc_pkg;
    // controller states
    typedef enum logic [3:0] {
        EVPSC_START,
        EVPSC_ST_RUN,
        EVPSC_ST_WAIT,
        EVPSC_ST_PASS,
        EVPSC_STATE_A,
        EVPSC_STATE_B,
        EVPSC_STATE_C,
        EVPSC_STATE_D,
        EVPSC_FAULT
    } evpsc_state_t;
endpackage

// ===== rtl/evpsc_ctrl.sv
/*
 * pilot state controller: self-test of the ground-fault detector, then
 * pilot signalling states a-d with relay control and latched faults.
 * assumes an external comparator bank gives a 3-bit band code of the
 * sampled pilot high level, and async fault inputs from the field.
 */
// Contract
// - state a: pilot held high, no pwm
// - drop to band b starts pwm
// - pwm near 1 khz at 25 percent
// - band c while modulating closes relay
// - band d seen in state c, behave as state c
// - self-test: 2 khz coil burst from tick
// - detector pulse expected within 30 ms
// - missing pulse: self-test fault, fault state
// - unplug from b or c returns to a
// - faults latch until restart only
`timescale 1ns/1ps
`include "evpsc_defines.svh"

module evpsc_ctrl
    import evpsc_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rstn_in,
    input wire logic [2:0] pilot_band_in, // sampled pilot band code
    input wire logic gfd_pulse_in, // ground-fault detector output
    input wire logic relay_stuck_in, // relay weld sense
    output logic pilot_out, // pilot drive, high = +12 v
    output logic relay_close_out, // power relay command
    output logic coil_out, // self-test coil drive
    output logic [3:0] state_out, // current state code
    output logic [3:0] fault_out // st, gf, relay, pilot
);

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [2:0] band_s1_reg; // first stage, read only by second
    logic [2:0] band_reg; // synced band code
    logic [2:0] band_d_reg; // synced code one cycle older
    logic gfd_s1_reg;
    logic gfd_reg;
    logic gfd_d_reg; // for edge detect
    logic stuck_s1_reg;
    logic stuck_reg;

    // two flops on every pin before use
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            band_s1_reg <= `EVPSC_BAND_A;
            band_reg <= `EVPSC_BAND_A;
            band_d_reg <= `EVPSC_BAND_A;
            gfd_s1_reg <= 1'b0;
            gfd_reg <= 1'b0;
            gfd_d_reg <= 1'b0;
            stuck_s1_reg <= 1'b0;
            stuck_reg <= 1'b0;
        end else begin
            band_s1_reg <= pilot_band_in;
            band_reg <= band_s1_reg;
            band_d_reg <= band_reg;
            gfd_s1_reg <= gfd_pulse_in;
            gfd_reg <= gfd_s1_reg;
            gfd_d_reg <= gfd_reg;
            stuck_s1_reg <= relay_stuck_in;
            stuck_reg <= stuck_s1_reg;
        end
    end

    // ---------------------------------------------------------------
    // band decode
    // ---------------------------------------------------------------
    // act on a code held two cycles; the sync can catch a mid-change
    wire band_steady = (band_reg == band_d_reg);
    wire in_a = band_steady && (band_reg == `EVPSC_BAND_A);
    wire in_b = band_steady && (band_reg == `EVPSC_BAND_B);
    wire in_c = band_steady && (band_reg == `EVPSC_BAND_C);
    wire in_d = band_steady && (band_reg == `EVPSC_BAND_D);
    wire in_inv = band_steady && (band_reg > `EVPSC_BAND_D); // 4 and up
    wire gfd_rise = gfd_reg && !gfd_d_reg;

    // ---------------------------------------------------------------
    // 4 khz background tick
    // ---------------------------------------------------------------
    logic [15:0] tick_cnt_reg;
    logic tick_reg; // one-cycle pulse at 4 khz
    wire tick_wrap = (tick_cnt_reg == 16'(`EVPSC_TICK_DIV - 1));

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            tick_cnt_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            tick_cnt_reg <= tick_wrap ? 16'h0000 : tick_cnt_reg + 16'h0001;
            tick_reg <= tick_wrap;
        end
    end

    // ---------------------------------------------------------------
    // state machine
    // ---------------------------------------------------------------
    evpsc_state_t state_reg, state_next;
    logic [7:0] st_cnt_reg; // burst / wait tick count
    logic [3:0] fault_reg; // latched faults
    logic [3:0] fault_next;
    wire signalling = (state_reg == EVPSC_STATE_A) ||
                      (state_reg == EVPSC_STATE_B) ||
                      (state_reg == EVPSC_STATE_C) ||
                      (state_reg == EVPSC_STATE_D);
    wire burst_done = (st_cnt_reg == 8'(`EVPSC_ST_BURST_TICKS - 1));
    // response window counts from burst start; wait gets the rest
    wire wait_over = (st_cnt_reg == 8'(`EVPSC_ST_WAIT_TICKS -
                      `EVPSC_ST_BURST_TICKS - 1));

    // faults only ever set; reset is the only clear
    always_comb begin
        fault_next = fault_reg;
        if (state_reg == EVPSC_ST_WAIT && tick_reg && wait_over &&
            !gfd_rise) begin
            fault_next[0] = 1'b1;
        end
        if (gfd_rise && state_reg != EVPSC_ST_RUN &&
            state_reg != EVPSC_ST_WAIT) begin
            fault_next[1] = 1'b1; // real ground fault trip
        end
        if (stuck_reg && state_reg != EVPSC_STATE_C &&
            state_reg != EVPSC_STATE_D) begin
            fault_next[2] = 1'b1; // relay closed when it should not be
        end
        if (signalling && in_inv) begin
            fault_next[3] = 1'b1;
        end
    end

    // next state; any latched fault wins
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            EVPSC_START: state_next = EVPSC_ST_RUN;
            EVPSC_ST_RUN: begin
                // the detector may answer during the burst already
                if (gfd_rise) begin
                    state_next = EVPSC_ST_PASS;
                end else if (tick_reg && burst_done) begin
                    state_next = EVPSC_ST_WAIT;
                end
            end
            EVPSC_ST_WAIT: begin
                if (gfd_rise) begin
                    state_next = EVPSC_ST_PASS;
                end
            end
            EVPSC_ST_PASS: state_next = EVPSC_STATE_A;
            EVPSC_STATE_A: begin
                if (in_b) begin
                    state_next = EVPSC_STATE_B;
                end
            end
            EVPSC_STATE_B: begin
                if (in_a) begin
                    state_next = EVPSC_STATE_A;
                end else if (in_c) begin
                    state_next = EVPSC_STATE_C;
                end
            end
            EVPSC_STATE_C: begin
                if (in_a) begin
                    state_next = EVPSC_STATE_A;
                end else if (in_b) begin
                    state_next = EVPSC_STATE_B;
                end else if (in_d) begin
                    state_next = EVPSC_STATE_D;
                end
            end
            // venting unsupported, fall back to c behaviour
            EVPSC_STATE_D: state_next = EVPSC_STATE_C;
            EVPSC_FAULT: state_next = EVPSC_FAULT;
        endcase
        if (fault_next != 4'h0) begin
            state_next = EVPSC_FAULT;
        end
    end

    // state, faults and self-test tick count
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_reg <= EVPSC_START;
            fault_reg <= 4'h0;
            st_cnt_reg <= 8'h00;
        end else begin
            state_reg <= state_next;
            fault_reg <= fault_next;
            if (state_next != state_reg) begin
                st_cnt_reg <= 8'h00;
            end else if (tick_reg) begin
                st_cnt_reg <= st_cnt_reg + 8'h01;
            end
        end
    end

    // ---------------------------------------------------------------
    // pilot pwm generator
    // ---------------------------------------------------------------
    logic [16:0] pwm_cnt_reg;
    wire pwm_wrap = (pwm_cnt_reg == 17'(`EVPSC_PWM_PERIOD - 1));
    wire pwm_high = (pwm_cnt_reg < 17'(`EVPSC_PWM_HIGH));
    // modulation runs in b, c and d; a holds dc high
    wire modulate = (state_next == EVPSC_STATE_B) ||
                    (state_next == EVPSC_STATE_C) ||
                    (state_next == EVPSC_STATE_D);
    wire pilot_next = modulate ? pwm_high : 1'b1;
    wire relay_next = (state_next == EVPSC_STATE_C) ||
                      (state_next == EVPSC_STATE_D);
    // coil toggles once per 4 khz tick, giving 2 khz
    wire coil_next = (state_reg == EVPSC_ST_RUN && state_next ==
                      EVPSC_ST_RUN) ? (coil_out ^ tick_reg) : 1'b0;

    // counter restarts on entering modulation for a clean first period
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pwm_cnt_reg <= 17'h00000;
        end else if (!modulate || pwm_wrap) begin
            pwm_cnt_reg <= 17'h00000;
        end else begin
            pwm_cnt_reg <= pwm_cnt_reg + 17'h00001;
        end
    end

    // ---------------------------------------------------------------
    // registered outputs
    // ---------------------------------------------------------------
    // pilot idles high so the vehicle sees state a from reset
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pilot_out <= 1'b1;
            relay_close_out <= 1'b0;
            coil_out <= 1'b0;
            state_out <= 4'h0;
            fault_out <= 4'h0;
        end else begin
            pilot_out <= pilot_next;
            relay_close_out <= relay_next;
            coil_out <= coil_next;
            state_out <= 4'(state_next);
            fault_out <= fault_next;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    chk_state_a_dc: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in)
        (state_reg == EVPSC_STATE_A) |-> pilot_out)
        else $error("pilot not dc high in state a");
    chk_b_starts_pwm: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in)
        (state_reg == EVPSC_STATE_A && state_next == EVPSC_STATE_B)
        |=> pilot_out ##1 pilot_out)
        else $error("pwm did not start high on entering b");
    chk_relay_in_c: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in)
        (state_reg == EVPSC_STATE_C) |-> relay_close_out)
        else $error("relay open in state c");
    chk_d_returns_c: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in)
        (state_reg == EVPSC_STATE_D) |=>
        (state_reg == EVPSC_STATE_C || state_reg == EVPSC_FAULT))
        else $error("state d did not return to c");
    chk_coil_on_tick: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in)
        $changed(coil_out) && $past(state_reg) == EVPSC_ST_RUN &&
        $past(state_next) == EVPSC_ST_RUN |-> $past(tick_reg))
        else $error("coil toggled off the tick");
    chk_st_timeout: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in)
        (state_reg == EVPSC_ST_WAIT && tick_reg && wait_over && !gfd_rise)
        |=> (state_reg == EVPSC_FAULT) && fault_out[0])
        else $error("missing self-test pulse not faulted");
    chk_unplug_to_a: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in)
        (state_reg == EVPSC_STATE_B && in_a && fault_next == 4'h0)
        |=> (state_reg == EVPSC_STATE_A))
        else $error("unplug did not return to a");
    chk_fault_sticky: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in)
        (state_reg == EVPSC_FAULT) |=> (state_reg == EVPSC_FAULT) &&
        !relay_close_out &&
        ((fault_reg & $past(fault_reg)) == $past(fault_reg)))
        else $error("fault state left or faults cleared");
    chk_invalid_band: assert property (@(posedge ref_clk_in)
        disable iff (!rstn_in)
        (signalling && in_inv) |=> fault_out[3] ##1 fault_out[3])
        else $error("invalid band not faulted");

endmodule

// ===== sim/ev_pilot_state_controller_test.sv
/*
 * self-checking bench for the pilot state controller with a car model.
 * assumes the counts of evpsc_defines.svh at a 125 MHz clock.
 */
`timescale 1ns/1ps
`include "evpsc_defines.svh"

module ev_pilot_state_controller_test import evpsc_pkg::*;;
    // ---------------------------------------------------------------
    // stimulus and wiring
    // ---------------------------------------------------------------
    logic ref_clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic gfd_pulse_in = 1'b0; // detector output
    logic relay_stuck_in = 1'b0; // relay weld sense
    logic [2:0] want = `EVPSC_BAND_A; // load asked of the car
    logic [2:0] band;
    logic pilot, relay, coil;
    logic [3:0] state, fault;
    int err_total = 0;
    int samples_checked = 0;
    int cyc = 0;
    int n;

    always #4 ref_clk_in = ~ref_clk_in;

    evpsc_ctrl evpsc_ctrl_inst (.ref_clk_in(ref_clk_in),
        .rstn_in(rstn_in), .pilot_band_in(band),
        .gfd_pulse_in(gfd_pulse_in), .relay_stuck_in(relay_stuck_in),
        .pilot_out(pilot), .relay_close_out(relay), .coil_out(coil),
        .state_out(state), .fault_out(fault));
    evpsc_vehicle evpsc_vehicle_inst (.clk_in(ref_clk_in),
        .pilot_in(pilot), .want_in(want), .band_out(band));

    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_total++;
            $display("Error at %0t ns: seen %0h expected %0h", $time,
                seen, exp);
        end
    endtask

    // one edge, then let its updates land before sampling
    task automatic step();
        @(posedge ref_clk_in);
        #1;
    endtask

    // bounded wait for a state code
    task automatic wait_state(input logic [3:0] s);
        for (int i = 0; i < 40 && state !== s; i++) step();
    endtask

    // cycles a signal keeps its present value, capped at lim
    task automatic hold_len(ref logic s, input int lim, output int len);
        logic v;
        v = s;
        len = 0;
        while (s === v && len < lim) begin
            step();
            len++;
        end
    endtask

    task automatic do_reset();
        @(posedge ref_clk_in);
        rstn_in <= 1'b0;
        want <= `EVPSC_BAND_A;
        gfd_pulse_in <= 1'b0;
        relay_stuck_in <= 1'b0;
        repeat (20) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
    endtask

    // detector pulse long enough for the two-flop sync
    task automatic gfd_pulse();
        @(posedge ref_clk_in);
        gfd_pulse_in <= 1'b1;
        repeat (4) @(posedge ref_clk_in);
        gfd_pulse_in <= 1'b0;
    endtask

    // reset and answer the self-test at once, ends in state a
    task automatic start_pass();
        do_reset();
        gfd_pulse();
        wait_state(EVPSC_STATE_A);
    endtask

    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_selftest();
        do_reset();
        step();
        check(state, EVPSC_ST_RUN);
        check({pilot, relay}, 2'h2);
        hold_len(coil, 31300, n); // first toggle
        hold_len(coil, 31300, n);
        check(n, `EVPSC_TICK_DIV * 32'h2 / 32'h2);
        gfd_pulse();
        wait_state(EVPSC_STATE_A);
        check(state, EVPSC_STATE_A);
        check(fault, 4'h0);
        $display("selftest done");
    endtask

    task automatic t_walk();
        start_pass();
        @(posedge ref_clk_in);
        want <= `EVPSC_BAND_B;
        #1;
        n = 0;
        while (state !== EVPSC_STATE_B && n < 40) begin
            step();
            n++;
        end
        check(n, 32'h5);
        hold_len(pilot, 200000, n);
        check(n, `EVPSC_PWM_HIGH);
        hold_len(pilot, 200000, n);
        check(n, `EVPSC_PWM_PERIOD - `EVPSC_PWM_HIGH);
        want <= `EVPSC_BAND_C;
        wait_state(EVPSC_STATE_C);
        check({state, relay}, {EVPSC_STATE_C, 1'b1});
        want <= `EVPSC_BAND_D;
        wait_state(EVPSC_STATE_D);
        check(state, EVPSC_STATE_D);
        step();
        check({state, relay}, {EVPSC_STATE_C, 1'b1});
        want <= `EVPSC_BAND_A;
        wait_state(EVPSC_STATE_A);
        check({state, relay, pilot}, {EVPSC_STATE_A, 2'h1});
        hold_len(pilot, 2000, n);
        check(n, 32'h7D0);
        gfd_pulse(); // trip outside the self-test
        wait_state(EVPSC_FAULT);
        check({state, fault[1]}, {EVPSC_FAULT, 1'b1});
        $display("walk done");
    endtask

    task automatic t_fault();
        start_pass();
        want <= `EVPSC_BAND_B;
        wait_state(EVPSC_STATE_B);
        want <= 3'h5; // invalid level
        wait_state(EVPSC_FAULT);
        check({state, fault[3], relay}, {EVPSC_FAULT, 2'h2});
        want <= `EVPSC_BAND_A;
        repeat (10) step();
        check({state, pilot}, {EVPSC_FAULT, 1'b1});
        @(posedge ref_clk_in);
        relay_stuck_in <= 1'b1; // weld sense with the relay open
        repeat (4) step();
        check({fault, relay}, {4'hC, 1'b0});
        $display("fault done");
    endtask

    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    task automatic wrap_up();
        $display("checked %0d, mismatches %0d", samples_checked,
            err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ceiling well above the one pwm period and coil ticks needed
    always @(posedge ref_clk_in) begin
        cyc++;
        if (cyc == 400000) begin
            err_total++;
            wrap_up();
        end
    end

    initial begin
        t_selftest();
        t_walk();
        t_fault();
        wrap_up();
    end
endmodule

// ===== sim/evpsc_vehicle.sv
/*
 * behavioural vehicle on the pilot wire: drives the sampled band code
 * that the comparator bank would report for the load it presents.
 * assumes the bench picks the wanted load and runs it on ref_clk_in.
 */
`timescale 1ns/1ps
`include "evpsc_defines.svh"

module evpsc_vehicle (
    input wire logic clk_in, // system clock
    input wire logic pilot_in, // pilot drive seen from the car side
    input wire logic [2:0] want_in, // load the bench asks for
    output logic [2:0] band_out // band code toward the controller
);
    // ---------------------------------------------------------------
    // load switching
    // ---------------------------------------------------------------
    logic pwm_seen_reg = 1'b0; // pwm observed since last plug-in

    // a real car only asks for charge once it sees pwm on the wire,
    // so charge or vent loads are held back as a plain plug-in
    always @(posedge clk_in) begin
        if (want_in == `EVPSC_BAND_A) begin
            pwm_seen_reg <= 1'b0; // unplugged, forget the pwm
        end else if (!pilot_in) begin
            pwm_seen_reg <= 1'b1;
        end
        if ((want_in == `EVPSC_BAND_C || want_in == `EVPSC_BAND_D)
            && !pwm_seen_reg) begin
            band_out <= `EVPSC_BAND_B; // wait for pwm first
        end else begin
            band_out <= want_in;
        end
    end
endmodule
